//--- verilog/pcl_pwm_ctrl.v
// shared pwm cycle length, cycle overflow and compare reload control
`timescale 1ns/1ps
`include "pcl_consts.vh"

//
// Contract
// - the overflow flag is set when the selected main counter bit overflows.
// - the cycle length select field picks the counter bit that sets the flag.
// - hardware or a written one sets the flag; only a written zero clears it.
// - the flag reads one after any overflow or written one since the last clear, else zero.
// - control bit 4 reads zero and writes to it are ignored.
// - with wide reload enabled, a counter overflow copies reload to compare.
// - wide reload enable acts on all channels in 16-bit pwm mode together.
// - with wide reload enable at zero no reload happens in 16-bit mode.
// - cycle length is the select field value plus eight bits.
// - the cycle length applies to all pwm channels not in 16-bit mode.
// - channels in 16-bit pwm mode ignore the cycle length select field.
// - the reload select bit steers compare accesses to the reload registers.
// - the overflow interrupt enable masks the flag onto the request.
// - a channel wide enable bit of one selects 16-bit pwm for that channel.
module pcl_pwm_ctrl #(
   parameter N_CH = 3
) (
   ref_clk,
   arst_n,
   count_tick,
   sfr_addr,
   sfr_wr,
   sfr_rd,
   sfr_wdata,
   sfr_rdata,
   main_counter,
   cycle_overflow_flag,
   cycle_overflow_irq,
   pwm_out
);
   input  wire            ref_clk;
   input  wire            arst_n;
   input  wire            count_tick;
   input  wire [7:0]      sfr_addr;
   input  wire            sfr_wr;
   input  wire            sfr_rd;
   input  wire [7:0]      sfr_wdata;
   output reg  [7:0]      sfr_rdata;
   output wire [15:0]     main_counter;
   output wire            cycle_overflow_flag;
   output wire            cycle_overflow_irq;
   output reg  [N_CH-1:0] pwm_out;

   // ****************************************************************
   // helpers
   // ****************************************************************
   function is_cmp_byte;
      input [7:0] addr;
      input integer ch;
      input       hi;
      reg   [7:0] want;
      begin
         // the base is even, so {ch, hi} is twice the channel plus hi
         want        = `PCL_CMP_BASE + {ch[6:0], hi};
         is_cmp_byte = (addr == want);
      end
   endfunction

   function masked_less;
      input [15:0] cnt;
      input [15:0] cmp;
      input [15:0] mask;
      begin
         masked_less = (cnt & mask) < (cmp & mask);
      end
   endfunction

   // ****************************************************************
   // state
   // ****************************************************************
   reg  [15:0]     counter_ff;
   reg             reload_select_ff;
   reg             irq_enable_ff;
   reg             overflow_ff;
   reg             wide_reload_ff;
   reg  [2:0]      cycle_len_ff;
   reg  [N_CH-1:0] wide_en_ff;
   reg  [15:0]     compare_ff [0:N_CH-1];
   reg  [15:0]     reload_ff  [0:N_CH-1];

   reg             nxt_overflow;
   reg  [7:0]      nxt_rdata;
   reg  [N_CH-1:0] cmp_lo_sel;
   reg  [N_CH-1:0] cmp_hi_sel;
   reg  [N_CH-1:0] reload_now;
   wire [15:0]     cycle_mask;
   wire            cycle_wrap;
   wire            main_wrap;
   wire            ctrl_sel;
   wire            mode_sel;
   wire            ctrl_wr;
   wire            mode_wr;
   wire [N_CH-1:0] cmp_lo_wr;
   wire [N_CH-1:0] cmp_hi_wr;
   wire [N_CH-1:0] rld_lo_wr;
   wire [N_CH-1:0] rld_hi_wr;
   wire [7:0]      ctrl_value;
   integer         i_dec;
   integer         i_rld;
   integer         i_cmp;
   integer         i_shd;
   integer         i_pwm;
   integer         i_rd;

   assign main_counter        = counter_ff;
   assign cycle_overflow_flag = overflow_ff;
   assign main_wrap  = count_tick & (counter_ff == `PCL_CNT_MAX);
   assign ctrl_sel   = (sfr_addr == `PCL_CTRL_ADDR);
   assign mode_sel   = (sfr_addr == `PCL_MODE_ADDR);
   assign ctrl_wr    = sfr_wr & ctrl_sel;
   assign mode_wr    = sfr_wr & mode_sel;
   assign cycle_overflow_irq = overflow_ff & irq_enable_ff;

   // bit 4 is left at zero here, so it always reads back as zero
   assign ctrl_value = {reload_select_ff, irq_enable_ff, overflow_ff,
                        1'b0, wide_reload_ff, cycle_len_ff};

   // ****************************************************************
   // address decode
   // ****************************************************************
   // decoded once and shared by the write and the read path, so the two
   // can never disagree about which byte an address names
   always @* begin
      cmp_lo_sel = {N_CH{1'b0}};
      cmp_hi_sel = {N_CH{1'b0}};
      for (i_dec = 0; i_dec < N_CH; i_dec = i_dec + 1) begin
         cmp_lo_sel[i_dec] = is_cmp_byte(sfr_addr, i_dec, 1'b0);
         cmp_hi_sel[i_dec] = is_cmp_byte(sfr_addr, i_dec, 1'b1);
      end
   end

   // the reload select bit steers a write to one side only
   assign cmp_lo_wr = cmp_lo_sel & {N_CH{sfr_wr & ~reload_select_ff}};
   assign cmp_hi_wr = cmp_hi_sel & {N_CH{sfr_wr & ~reload_select_ff}};
   assign rld_lo_wr = cmp_lo_sel & {N_CH{sfr_wr & reload_select_ff}};
   assign rld_hi_wr = cmp_hi_sel & {N_CH{sfr_wr & reload_select_ff}};

   // ****************************************************************
   // cycle length selection
   // ****************************************************************
   pcl_cycle_sel u_cycle_sel (
      .count      (counter_ff),
      .count_tick (count_tick),
      .cycle_length_select      (cycle_len_ff),
      .cycle_mask (cycle_mask),
      .cycle_wrap (cycle_wrap)
   );

   // ****************************************************************
   // main counter
   // ****************************************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_ff <= `PCL_CNT_RESET;
      end else if (count_tick) begin
         counter_ff <= counter_ff + 16'h0001;
      end
   end

   // ****************************************************************
   // control register
   // ****************************************************************
   always @* begin
      nxt_overflow = overflow_ff;
      if (ctrl_wr) begin
         nxt_overflow = sfr_wdata[`PCL_CYCLE_OVERFLOW_FLAG_BIT];
      end
      // an overflow in the same cycle as a clearing write still sticks
      if (cycle_wrap) begin
         nxt_overflow = 1'b1;
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reload_select_ff <= 1'b0;
         irq_enable_ff    <= 1'b0;
         overflow_ff      <= 1'b0;
         wide_reload_ff   <= 1'b0;
         cycle_len_ff     <= 3'h0;
         wide_en_ff       <= {N_CH{1'b0}};
      end else begin
         overflow_ff <= nxt_overflow;
         if (ctrl_wr) begin
            reload_select_ff <= sfr_wdata[`PCL_RSEL_BIT];
            irq_enable_ff    <= sfr_wdata[`PCL_IRQEN_BIT];
            wide_reload_ff   <= sfr_wdata[`PCL_WRLD_BIT];
            cycle_len_ff     <= sfr_wdata[`PCL_CYCLE_LENGTH_SELECT_MSB:`PCL_CYCLE_LENGTH_SELECT_LSB];
         end
         if (mode_wr) begin
            wide_en_ff <= sfr_wdata[N_CH-1:0];
         end
      end
   end

   // ****************************************************************
   // compare and reload registers
   // ****************************************************************
   // 8 bit pwm has no reload, so its compare value acts as written
   always @* begin
      reload_now = {N_CH{1'b0}};
      for (i_rld = 0; i_rld < N_CH; i_rld = i_rld + 1) begin
         if (wide_en_ff[i_rld]) begin
            // one enable for every wide channel; off means no copy
            if (wide_reload_ff) begin
               reload_now[i_rld] = main_wrap;
            end
         end else if (cycle_len_ff != 3'h0) begin
            // 9 to 15 bit pwm takes its new value at each cycle end
            reload_now[i_rld] = cycle_wrap;
         end
      end
   end

   // a software write to a compare byte lands after the reload copy in
   // the same cycle, so the written byte wins over the automatic copy
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (i_cmp = 0; i_cmp < N_CH; i_cmp = i_cmp + 1) begin
            compare_ff[i_cmp] <= `PCL_CMP_RESET;
         end
      end else begin
         for (i_cmp = 0; i_cmp < N_CH; i_cmp = i_cmp + 1) begin
            if (reload_now[i_cmp]) begin
               compare_ff[i_cmp] <= reload_ff[i_cmp];
            end
            if (cmp_lo_wr[i_cmp]) begin
               compare_ff[i_cmp][7:0] <= sfr_wdata;
            end
            if (cmp_hi_wr[i_cmp]) begin
               compare_ff[i_cmp][15:8] <= sfr_wdata;
            end
         end
      end
   end

   // the reload side is written by software only
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (i_shd = 0; i_shd < N_CH; i_shd = i_shd + 1) begin
            reload_ff[i_shd] <= `PCL_CMP_RESET;
         end
      end else begin
         for (i_shd = 0; i_shd < N_CH; i_shd = i_shd + 1) begin
            if (rld_lo_wr[i_shd]) begin
               reload_ff[i_shd][7:0] <= sfr_wdata;
            end
            if (rld_hi_wr[i_shd]) begin
               reload_ff[i_shd][15:8] <= sfr_wdata;
            end
         end
      end
   end

   // ****************************************************************
   // pwm outputs
   // ****************************************************************
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_out <= {N_CH{1'b0}};
      end else begin
         for (i_pwm = 0; i_pwm < N_CH; i_pwm = i_pwm + 1) begin
            if (wide_en_ff[i_pwm]) begin
               // full counter width, cycle length field not consulted
               pwm_out[i_pwm] <= counter_ff < compare_ff[i_pwm];
            end else begin
               pwm_out[i_pwm] <= masked_less(counter_ff,
                                             compare_ff[i_pwm],
                                             cycle_mask);
            end
         end
      end
   end

   // ****************************************************************
   // register read
   // ****************************************************************
   always @* begin
      nxt_rdata = 8'h00;
      if (ctrl_sel) begin
         nxt_rdata = ctrl_value;
      end else if (mode_sel) begin
         nxt_rdata[N_CH-1:0] = wide_en_ff;
      end
      for (i_rd = 0; i_rd < N_CH; i_rd = i_rd + 1) begin
         if (cmp_lo_sel[i_rd]) begin
            nxt_rdata = reload_select_ff ? reload_ff[i_rd][7:0]
                                         : compare_ff[i_rd][7:0];
         end
         if (cmp_hi_sel[i_rd]) begin
            nxt_rdata = reload_select_ff ? reload_ff[i_rd][15:8]
                                         : compare_ff[i_rd][15:8];
         end
      end
   end

   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= nxt_rdata;
      end
   end

endmodule // pcl_pwm_ctrl

//--- verilog/pcl_consts.vh
// register map, field positions and reset values of the pwm cycle control
`ifndef PCL_CONSTS_VH
`define PCL_CONSTS_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define PCL_CTRL_ADDR     8'h00
`define PCL_MODE_ADDR     8'h01
`define PCL_CMP_BASE      8'h10

// ****************************************************************
// control register fields
// ****************************************************************
`define PCL_RSEL_BIT      7
`define PCL_IRQEN_BIT     6
`define PCL_CYCLE_OVERFLOW_FLAG_BIT      5
`define PCL_UNUSED_BIT    4
`define PCL_WRLD_BIT      3
`define PCL_CYCLE_LENGTH_SELECT_MSB     2
`define PCL_CYCLE_LENGTH_SELECT_LSB     0

// ****************************************************************
// reset values and counts
// ****************************************************************
`define PCL_CTRL_RESET    8'h00
`define PCL_MODE_RESET    8'h00
`define PCL_CMP_RESET     16'h0000
`define PCL_CNT_RESET     16'h0000
`define PCL_CNT_MAX       16'hffff
`define PCL_LEN_BASE      5'h08

`endif

//--- verilog/pcl_cycle_sel.v
// cycle length mask and selected counter bit wrap detection
`timescale 1ns/1ps
`include "pcl_consts.vh"

module pcl_cycle_sel (
   count,
   count_tick,
   cycle_length_select,
   cycle_mask,
   cycle_wrap
);
   input  wire [15:0] count;
   input  wire        count_tick;
   input  wire [2:0]  cycle_length_select;
   output wire [15:0] cycle_mask;
   output wire        cycle_wrap;

   wire [4:0] len;

   // code 000 gives 8 bits, code 111 gives 15 bits
   assign len        = {2'h0, cycle_length_select} + `PCL_LEN_BASE;
   assign cycle_mask = ~(`PCL_CNT_MAX << len);
   // the low field wraps from all ones to zero on this tick
   assign cycle_wrap = count_tick &
                       ((count & cycle_mask) == cycle_mask);

endmodule // pcl_cycle_sel

//--- verif/pcl_pwm_ctrl_assertions.sv
// port level checks of the pwm cycle control
`timescale 1ns/1ps
module pcl_pwm_ctrl_chk (
   input wire        ref_clk,
   input wire        arst_n,
   input wire        count_tick,
   input wire [7:0]  sfr_addr,
   input wire        sfr_wr,
   input wire        sfr_rd,
   input wire [7:0]  sfr_wdata,
   input wire [7:0]  sfr_rdata,
   input wire [15:0] main_counter,
   input wire        cycle_overflow_flag,
   input wire        cycle_overflow_irq
);
   // ****************************************************************
   // shadow of the control register, rebuilt from bus writes
   // ****************************************************************
   reg  [7:0]  ctrl_ff;
   wire        ctl_wr = sfr_wr && (sfr_addr == 8'h00);
   wire [15:0] mask = (16'h0001 << (ctrl_ff[2:0] + 4'h8)) - 16'h0001;
   wire        wrap = count_tick && ((main_counter & mask) == mask);
   wire        clr = ctl_wr && !sfr_wdata[5];
   wire        setw = ctl_wr && sfr_wdata[5];
   wire [7:0]  view = {ctrl_ff[7:6], cycle_overflow_flag, 1'b0, ctrl_ff[3:0]};
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         ctrl_ff <= 8'h00;
      else if (ctl_wr)
         ctrl_ff <= sfr_wdata;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   flag_set_a: assert property (wrap |=> cycle_overflow_flag)
      else $error("flag missed a wrap");
   flag_cause_a: assert property (
      $rose(cycle_overflow_flag) |-> $past(wrap || setw))
      else $error("flag rose without cause");
   flag_hold_a: assert property (
      cycle_overflow_flag && !clr |=> cycle_overflow_flag)
      else $error("flag dropped");
   flag_clear_a: assert property (clr && !wrap |=> !cycle_overflow_flag)
      else $error("flag not cleared");
   irq_mask_a: assert property (
      cycle_overflow_irq == (cycle_overflow_flag && ctrl_ff[6]))
      else $error("irq not flag and enable");
   cnt_step_a: assert property (
      count_tick |=> main_counter == $past(main_counter) + 16'h0001)
      else $error("counter did not step");
   cnt_hold_a: assert property (!count_tick |=> $stable(main_counter))
      else $error("counter moved");
   ctrl_read_a: assert property (
      sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == $past(view))
      else $error("control read wrong");
endmodule // pcl_pwm_ctrl_chk

bind pcl_pwm_ctrl pcl_pwm_ctrl_chk i_pcl_pwm_ctrl_chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .count_tick(count_tick),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .main_counter(main_counter), .cycle_overflow_flag(cycle_overflow_flag),
   .cycle_overflow_irq(cycle_overflow_irq));

//--- verif/tb_top.sv
// self-checking bench of the pwm cycle control
`timescale 1ns/1ps
module tb_top;
   reg         ref_clk = 1'b0;
   reg         arst_n = 1'b0;
   reg         count_tick = 1'b0;
   reg  [7:0]  sfr_addr = 8'h00;
   reg         sfr_wr = 1'b0;
   reg         sfr_rd = 1'b0;
   reg  [7:0]  sfr_wdata = 8'h00;
   wire [7:0]  sfr_rdata;
   wire [15:0] main_counter;
   wire        cycle_overflow_flag;
   wire        cycle_overflow_irq;
   wire [2:0]  pwm_out;
   reg  [15:0] cnt_e = 16'h0000;
   reg  [15:0] msk;
   integer     n_mismatch = 0;
   integer     n_checks = 0;
   integer     i;
   always #12.5 ref_clk = ~ref_clk;
   pcl_pwm_ctrl #(.N_CH(3)) i_pcl_pwm_ctrl (
      .ref_clk(ref_clk), .arst_n(arst_n), .count_tick(count_tick),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .main_counter(main_counter), .cycle_overflow_flag(cycle_overflow_flag),
      .cycle_overflow_irq(cycle_overflow_irq), .pwm_out(pwm_out));
   // ****************************************************************
   // bus and counter tasks
   // ****************************************************************
   task finish_test;
      begin
         if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge ref_clk);
         sfr_addr = a;
         sfr_wdata = d;
         sfr_wr = 1'b1;
         @(negedge ref_clk);
         sfr_wr = 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(negedge ref_clk);
         sfr_addr = a;
         sfr_rd = 1'b1;
         @(negedge ref_clk);
         sfr_rd = 1'b0;
         chk({8'h00, sfr_rdata}, {8'h00, e});
      end
   endtask
   // ticks run back to back so the long wraps stay cheap in cycles
   task tick(input integer n);
      begin
         @(negedge ref_clk);
         count_tick = 1'b1;
         repeat (n) @(negedge ref_clk);
         count_tick = 1'b0;
         cnt_e = cnt_e + n[15:0];
         chk(main_counter, cnt_e);
      end
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      arst_n = 1'b1;
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      wr(8'h00, 8'hff);
      rd(8'h00, 8'hef);
      chk({15'h0000, cycle_overflow_irq}, 16'h0001);
      wr(8'h00, 8'h20);
      chk({15'h0000, cycle_overflow_irq}, 16'h0000);
      rd(8'h00, 8'h20);
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h00, i[7:0]);
         rd(8'h00, i[7:0]);
         msk = (16'h0001 << (i + 8)) - 16'h0001;
         tick({16'h0000, msk - (cnt_e & msk)});
         chk({15'h0000, cycle_overflow_flag}, 16'h0000);
         tick(1);
         chk({15'h0000, cycle_overflow_flag}, 16'h0001);
         chk(main_counter & msk, 16'h0000);
      end
      // reload select high: compare bytes land in the reload side
      wr(8'h00, 8'h80);
      wr(8'h10, 8'h34);
      wr(8'h11, 8'h12);
      wr(8'h12, 8'h78);
      wr(8'h13, 8'h56);
      rd(8'h10, 8'h34);
      wr(8'h00, 8'h08);
      rd(8'h10, 8'h00);
      wr(8'h01, 8'h03);
      tick({16'h0000, 16'hffff - cnt_e} + 1);
      rd(8'h10, 8'h34);
      rd(8'h11, 8'h12);
      rd(8'h12, 8'h78);
      rd(8'h13, 8'h56);
      chk({13'h0000, pwm_out}, 16'h0003);
      // narrow channel 2 compare 0x0180 written directly, counter to 0x90
      wr(8'h14, 8'h80);
      wr(8'h15, 8'h01);
      tick(32'h00000090);
      rd(8'h15, 8'h01);
      // 8 bit: 0x90 < 0x80 fails for ch2; wide ch0/ch1 use all 16 bits
      chk({13'h0000, pwm_out}, 16'h0003);
      wr(8'h00, 8'h09);
      rd(8'h00, 8'h09);
      // 9 bit: 0x090 < 0x180 holds for ch2
      chk({13'h0000, pwm_out}, 16'h0007);
      finish_test;
   end
endmodule // tb_top
